// ===== rtl/ppr_channel.sv
// one link channel: apb registers, link sampler and frame engine
// assumes open-drain pins resolved outside; peripheral clocks the link
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ppr_channel
    import ppr_pkg::*;
#(
    parameter int BIT_TO_CYC = PPR_BIT_TO_CYC,
    parameter int STA_TO_CYC = PPR_STA_TO_CYC,
    parameter int FRM_TO_CYC = PPR_FRM_TO_CYC
) (
    // system clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // link pins
    input  wire logic          link_clk,
    input  wire logic          link_data_in,
    output ppr_link_out_t      link_out
);
    // --------------------------------------------------------------
    // parameter check
    // --------------------------------------------------------------
    if (BIT_TO_CYC < 1 || STA_TO_CYC < 1 || FRM_TO_CYC < 1 ||
        BIT_TO_CYC >= (1 << PPR_TMR_W) || STA_TO_CYC >= (1 << PPR_TMR_W) ||
        FRM_TO_CYC >= (1 << PPR_TMR_W)) begin : g_bad_param
        $error("timeout counts outside timer range");
    end

    // --------------------------------------------------------------
    // link domain: sample data on each falling link clock edge
    // --------------------------------------------------------------
    logic [1:0]  lrst_sync; // reset brought into the link domain
    logic [10:0] lnk_shift; // last eleven bits, newest at top
    logic        lnk_tog;   // flips on every falling edge

    // the clock may stand still, so reset only settles on edges
    always_ff @(negedge link_clk) begin
        lrst_sync <= {lrst_sync[0], rst_n};
    end

    // shift in the data line; one toggle per edge tells the sys side
    always_ff @(negedge link_clk) begin
        if (!lrst_sync[1]) begin
            lnk_shift <= '1;
            lnk_tog   <= 1'b0;
        end else begin
            lnk_shift <= {link_data_in, lnk_shift[10:1]};
            lnk_tog   <= ~lnk_tog;
        end
    end

    // --------------------------------------------------------------
    // crossing: toggle through two flops, edge found after them
    // --------------------------------------------------------------
    logic [2:0] tog_sync; // [0] feeds only [1]

    always_ff @(posedge sys_clk) begin
        if (!rst_n) tog_sync <= 3'h0;
        else        tog_sync <= {tog_sync[1:0], lnk_tog};
    end
    // shift word is stable for a whole bit cell after the toggle
    wire link_fall = tog_sync[2] ^ tog_sync[1];
    wire [10:0] frame = lnk_shift;

    // --------------------------------------------------------------
    // state and register storage
    // --------------------------------------------------------------
    ppr_state_t             state, next_state; // frame engine
    ppr_ctrl_t              ctrl;        // channel_control
    logic [7:0]             rx_byte;     // rx_byte_read_port
    logic [9:0]             tx_shift;    // stop, parity, data
    logic                   rdata_rdy;   // receive-ready flag
    logic                   tx_idle;     // tx_idle_flag
    logic                   xmit_to;     // transmit timeout flag
    logic                   start_to;    // start timeout flag
    logic [3:0]             bit_cnt;     // falling edges this frame
    logic [PPR_TMR_W-1:0]   bit_tmr;     // since last edge / hold
    logic [PPR_TMR_W-1:0]   frm_tmr;     // since start / first edge
    logic                   pready_q;    // one wait state

    // --------------------------------------------------------------
    // apb decode
    // --------------------------------------------------------------
    wire apb_acc  = psel & penable;
    wire hit_data = (paddr == PPR_OFF_DATA);
    wire hit_ctrl = (paddr == PPR_OFF_CTRL);
    wire hit_stat = (paddr == PPR_OFF_STAT);
    wire addr_ok  = hit_data | hit_ctrl | hit_stat;
    wire wr_xfer  = apb_acc & pready_q & pwrite;
    wire rd_xfer  = apb_acc & pready_q & ~pwrite;
    wire rd_data  = rd_xfer & hit_data;
    wire rd_stat  = rd_xfer & hit_stat;
    wire wr_ctrl  = wr_xfer & hit_ctrl;
    wire wr_stat  = wr_xfer & hit_stat;
    // blocked while disabled, receiving or a byte still pending
    wire tx_wr    = wr_xfer & hit_data & ctrl.channel_enable &
                    ctrl.direction_select & tx_idle;

    wire [7:0] status = {start_to, (state == ST_RX), xmit_to, tx_idle,
                         3'h0, rdata_rdy};
    wire [31:0] rd_mux = hit_data ? {24'h0, rx_byte} :
                         hit_ctrl ? {26'h0, ctrl} :
                         hit_stat ? {24'h0, status} : 32'h0;

    assign pready  = pready_q;
    assign pslverr = pready_q & ~addr_ok; // unmapped address

    // answer one cycle into the access phase, data already latched
    always_ff @(posedge sys_clk) begin
        if (!rst_n) pready_q <= 1'b0;
        else        pready_q <= apb_acc & ~pready_q;
    end

    // read data is captured in the first access cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n)                              prdata <= 32'h0;
        else if (apb_acc & ~pready_q & ~pwrite)  prdata <= rd_mux;
    end

    // --------------------------------------------------------------
    // frame checks and timeouts
    // --------------------------------------------------------------
    wire frame_end = link_fall & (bit_cnt == PPR_LAST_EDGE);
    wire par_ok   = (ctrl.parity_mode == PPR_CHK_HIGH) ? ^frame[9:1] :
                    (ctrl.parity_mode == PPR_CHK_LOW) ? ~^frame[9:1] :
                    1'b1;
    wire stop_ok  = (ctrl.stop_level == PPR_CHK_HIGH) ? frame[10] :
                    (ctrl.stop_level == PPR_CHK_LOW) ? ~frame[10] :
                    1'b1;
    // checks only mean anything while the channel runs
    wire rx_good  = (state == ST_RX) & frame_end & ctrl.channel_enable &
                    ~frame[0] & par_ok & stop_ok;
    wire bit_late = (bit_cnt != 4'h0) &
                    (bit_tmr >= PPR_TMR_W'(BIT_TO_CYC));
    wire sta_late = (state == ST_TX_RUN) & (bit_cnt == 4'h0) &
                    (frm_tmr >= PPR_TMR_W'(STA_TO_CYC));
    wire frm_late = (bit_cnt != 4'h0) & (bit_cnt < PPR_LAST_EDGE) &
                    (frm_tmr >= PPR_TMR_W'(FRM_TO_CYC));
    wire tx_to    = (state == ST_TX_RUN) & (bit_late | sta_late | frm_late);
    wire rx_to    = (state == ST_RX) & bit_late;
    wire hold_done = bit_tmr >= PPR_TMR_W'(BIT_TO_CYC);
    wire tx_done  = (state == ST_TX_RUN) & frame_end;
    wire next_rdy = rx_good | (rdata_rdy & ~rd_data);

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (!ctrl.channel_enable) begin
            next_state = ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (ctrl.direction_select)
                        next_state = ST_TX_WAIT;
                    else if (link_fall & ~rdata_rdy)
                        next_state = ST_RX;
                end
                ST_RX: begin
                    // turning to transmit mid-frame drops the byte
                    if (ctrl.direction_select | frame_end | rx_to)
                        next_state = ST_IDLE;
                end
                ST_TX_WAIT: begin
                    if (!ctrl.direction_select)
                        next_state = ST_IDLE;
                    else if (!tx_idle & ~rdata_rdy)
                        next_state = ST_TX_RUN;
                end
                ST_TX_RUN: begin
                    if (!ctrl.direction_select) next_state = ST_IDLE;
                    else if (tx_to)             next_state = ST_TO_HOLD;
                    else if (frame_end)         next_state = ST_IDLE;
                end
                ST_TO_HOLD: begin
                    if (rd_stat & hold_done) next_state = ST_IDLE;
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    wire state_chg = (next_state != state);

    // engine state register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) state <= ST_IDLE;
        else        state <= next_state;
    end

    // edge counter: the first receive edge is already the start bit
    always_ff @(posedge sys_clk) begin
        if (!rst_n)         bit_cnt <= 4'h0;
        else if (state_chg) bit_cnt <= (next_state == ST_RX) ? 4'h1 : 4'h0;
        else if (link_fall) bit_cnt <= bit_cnt + 4'h1;
    end

    // bit timer, also the hold timer after a timeout; saturates
    always_ff @(posedge sys_clk) begin
        if (!rst_n || state_chg || link_fall) bit_tmr <= '0;
        else if (bit_tmr != '1)               bit_tmr <= bit_tmr + 1'b1;
    end

    // frame timer restarts at the first edge of a transmit
    always_ff @(posedge sys_clk) begin
        if (!rst_n || state_chg || (link_fall && bit_cnt == 4'h0))
            frm_tmr <= '0;
        else if (frm_tmr != '1)
            frm_tmr <= frm_tmr + 1'b1;
    end

    // --------------------------------------------------------------
    // control register; hardware clears the direction bit
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl <= PPR_CTRL_RESET;
        end else begin
            if (wr_ctrl) ctrl <= ppr_ctrl_t'(pwdata[5:0]);
            // the end of a frame beats a same-cycle write
            if (tx_done | tx_to | xmit_to) ctrl.direction_select <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // receive byte and ready flag
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n)                         rx_byte <= PPR_RX_RESET;
        else if (rx_good)                   rx_byte <= frame[8:1];
        else if (rd_data | rx_to | tx_to)   rx_byte <= PPR_RX_RESET;
    end

    // set wins over the clearing read
    always_ff @(posedge sys_clk) begin
        if (!rst_n) rdata_rdy <= 1'b0;
        else        rdata_rdy <= next_rdy;
    end

    // --------------------------------------------------------------
    // status flags, write one to clear, set wins
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            xmit_to  <= 1'b0;
            start_to <= 1'b0;
        end else begin
            xmit_to  <= tx_to | (xmit_to & ~(wr_stat & pwdata[PPR_ST_XTO]));
            start_to <= (tx_to & sta_late) |
                        (start_to & ~(wr_stat & pwdata[PPR_ST_STO]));
        end
    end

    // idle unless a byte is accepted and its frame is still waiting or running
    always_ff @(posedge sys_clk) begin
        if (!rst_n)      tx_idle <= 1'b1;
        else if (tx_wr)  tx_idle <= 1'b0;
        else if (next_state != ST_TX_WAIT && next_state != ST_TX_RUN)
            tx_idle <= 1'b1;
    end

    // --------------------------------------------------------------
    // transmit shifter: changes data after each of the first ten falling edges
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            tx_shift <= 10'h3FF;
        else if (tx_wr)
            tx_shift <= {1'b1, ~^pwdata[7:0], pwdata[7:0]};
        else if (state == ST_TX_RUN && link_fall && bit_cnt < PPR_LAST_EDGE)
            tx_shift <= {1'b1, tx_shift[9:1]};
    end

    // --------------------------------------------------------------
    // pin drivers; both change on the same edge at transmit start
    // --------------------------------------------------------------
    wire start_tx = (state == ST_TX_WAIT) & (next_state == ST_TX_RUN);
    wire next_clk_oe = ~ctrl.channel_enable | (next_state == ST_TX_WAIT) |
                       (next_state == ST_TO_HOLD) |
                       ((next_state == ST_IDLE) & next_rdy);
    wire next_dat_oe = start_tx ? 1'b1 :
                       (next_state != ST_TX_RUN) ? 1'b0 :
                       (link_fall && bit_cnt < PPR_LAST_EDGE) ? ~tx_shift[0] :
                       link_out.dat_oe;

    // open drain: only ever pull low
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            link_out <= '{clk_out: 1'b0, clk_oe: 1'b1, dat_out: 1'b0,
                          dat_oe: 1'b0};
        end else begin
            link_out.clk_out <= 1'b0;
            link_out.dat_out <= 1'b0;
            link_out.clk_oe  <= next_clk_oe;
            link_out.dat_oe  <= next_dat_oe;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_tx_start;
        state == ST_TX_WAIT && next_state == ST_TX_RUN;
    endsequence
    sequence s_rx_done;
        rx_good ##1 rdata_rdy;
    endsequence

    property p_tx_launch;
        tx_wr |=> !tx_idle;
    endproperty
    a_tx_launch: assert property (p_tx_launch)
        else $error("accepted byte did not mark transmitter busy");

    property p_rx_store;
        rx_good |=> rx_byte == $past(frame[8:1]) && rdata_rdy;
    endproperty
    a_rx_store: assert property (p_rx_store)
        else $error("received byte not stored");

    property p_tx_hold;
        (state == ST_TX_WAIT && rdata_rdy) |=> state != ST_TX_RUN;
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit started with byte pending");

    property p_rx_reload;
        (rd_data && !rx_good) |=> rx_byte == 8'hFF && !rdata_rdy;
    endproperty
    a_rx_reload: assert property (p_rx_reload)
        else $error("receive byte not reloaded after read");

    property p_stop_low;
        (state == ST_RX && frame_end && ctrl.stop_level == PPR_CHK_LOW &&
         frame[10]) |=> !rdata_rdy;
    endproperty
    a_stop_low: assert property (p_stop_low)
        else $error("high stop accepted while low expected");

    property p_par_even;
        (state == ST_RX && frame_end && ctrl.parity_mode == PPR_CHK_LOW &&
         ^frame[9:1]) |=> !rdata_rdy;
    endproperty
    a_par_even: assert property (p_par_even)
        else $error("odd parity accepted while even expected");

    property p_disabled;
        !ctrl.channel_enable [*2] |-> link_out.clk_oe && !link_out.dat_oe &&
                                      state == ST_IDLE;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled channel not inhibiting the link");

    property p_dir_tx;
        (ctrl.channel_enable && ctrl.direction_select && state == ST_IDLE)
            |=> state == ST_TX_WAIT;
    endproperty
    a_dir_tx: assert property (p_dir_tx)
        else $error("transmit direction not taken");

    property p_rd_ctrl;
        (apb_acc && !pready_q && !pwrite && hit_ctrl && !wr_ctrl)
            |=> prdata == {26'h0, $past(ctrl)};
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl)
        else $error("control readback wrong");

    property p_reset_ctrl;
        $rose(rst_n) |-> ctrl == PPR_CTRL_RESET && rx_byte == 8'hFF;
    endproperty
    a_reset_ctrl: assert property (p_reset_ctrl)
        else $error("reset values wrong");

    property p_rx_clk_low;
        s_rx_done |-> link_out.clk_oe;
    endproperty
    a_rx_clk_low: assert property (p_rx_clk_low)
        else $error("clock not held after reception");

    property p_tx_start;
        s_tx_start |=> link_out.dat_oe && !link_out.clk_oe;
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("transmit start pin drive wrong");

    property p_tx_end;
        tx_done |=> !ctrl.direction_select && tx_idle && state == ST_IDLE;
    endproperty
    a_tx_end: assert property (p_tx_end)
        else $error("transmit end did not return to idle");
endmodule // ppr_channel
`default_nettype wire

// ===== rtl/ppr_pkg.sv
// constants, types and register map of the link channel controller
// assumes a 20 MHz system clock and a 32-bit apb register bus
package ppr_pkg;
    // --------------------------------------------------------------
    // register offsets (byte addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] PPR_OFF_DATA = 8'h00; // tx write, rx read
    localparam logic [7:0] PPR_OFF_CTRL = 8'h04; // channel_control
    localparam logic [7:0] PPR_OFF_STAT = 8'h08; // channel_status
    // --------------------------------------------------------------
    // reset values and field positions
    // --------------------------------------------------------------
    localparam logic [7:0] PPR_RX_RESET = 8'hFF; // idle receive byte
    localparam logic [5:0] PPR_CTRL_RESET = 6'h00; // all fields zero
    localparam int PPR_ST_RDY  = 0; // receive-ready flag
    localparam int PPR_ST_IDLE = 4; // tx_idle_flag
    localparam int PPR_ST_XTO  = 5; // transmit timeout, write 1 clears
    localparam int PPR_ST_BUSY = 6; // receiving
    localparam int PPR_ST_STO  = 7; // start timeout, write 1 clears
    localparam logic [1:0] PPR_CHK_HIGH = 2'h0; // stop high / odd parity
    localparam logic [1:0] PPR_CHK_LOW  = 2'h1; // stop low / even parity
    localparam logic [3:0] PPR_LAST_EDGE = 4'hA; // count before 11th edge
    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int PPR_CLK_NS    = 50;  // system clock period
    localparam int PPR_BIT_TO_US = 300; // longest bit time
    localparam int PPR_STA_TO_MS = 25;  // start bit wait
    localparam int PPR_FRM_TO_MS = 2;   // start to parity
    localparam int PPR_REL_NS    = 80;  // clock release after start; not used, the clock is released on the same edge as the start bit
    localparam int PPR_BIT_TO_CYC = PPR_BIT_TO_US * 1000 / PPR_CLK_NS;
    localparam int PPR_STA_TO_CYC = PPR_STA_TO_MS * 1000000 / PPR_CLK_NS;
    localparam int PPR_FRM_TO_CYC = PPR_FRM_TO_MS * 1000000 / PPR_CLK_NS;
    localparam int PPR_REL_CYC = (PPR_REL_NS / PPR_CLK_NS < 1) ? 1 :
                                 PPR_REL_NS / PPR_CLK_NS;
    localparam int PPR_TMR_W = 19; // timer width
    // --------------------------------------------------------------
    // types
    // --------------------------------------------------------------
    typedef struct packed {
        logic [1:0] stop_level;       // bits 5:4
        logic [1:0] parity_mode;      // bits 3:2
        logic       channel_enable;   // bit 1
        logic       direction_select; // bit 0
    } ppr_ctrl_t;
    typedef struct packed {
        logic clk_out; // link_clock_pin level when driven
        logic clk_oe;  // link_clock_pin driven
        logic dat_out; // link_data_pin level when driven
        logic dat_oe;  // link_data_pin driven
    } ppr_link_out_t;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_RX      = 3'h1,
        ST_TX_WAIT = 3'h3,
        ST_TX_RUN  = 3'h2,
        ST_TO_HOLD = 3'h6
    } ppr_state_t;
endpackage

// ===== sim/ppr_dev_model.sv
// behavioural link peripheral: clocks the link, open-drain pull-downs
// assumes the bench resolves both wires with a pull-up
`timescale 1ns/10ps
`default_nettype none
module ppr_dev_model (
    // resolved wire levels
    input  wire logic clk_w,
    input  wire logic dat_w,
    // pull-downs driven by the peripheral
    output logic      clk_low,
    output logic      dat_low
);
    // ------------------------------------------------
    // frame tasks
    // ------------------------------------------------
    initial begin
        clk_low = 1'b0;
        dat_low = 1'b0;
    end
    // send one frame; par and stp are raw bits so checks can be provoked
    task automatic send(input logic [7:0] b, input logic par, input logic stp);
        logic [10:0] f;
        f = {stp, par, b, 1'b0};
        wait (clk_w === 1'b1); // host inhibit is respected
        for (int k = 0; k < 11; k++) begin
            dat_low = ~f[k];
            #31.25 clk_low = 1'b1;
            #62.5 clk_low = 1'b0;
            #31.25;
        end
        dat_low = 1'b0;
    endtask
    // clock a frame in from the host; long high phase covers its latency
    task automatic recv(output logic [10:0] f);
        f = 11'h000;
        wait (clk_w === 1'b1 && dat_w === 1'b0);
        #100 f[0] = dat_w;
        for (int k = 1; k < 12; k++) begin
            clk_low = 1'b1;
            dat_low = (k == 11); // ack in the last cell
            #62.5 clk_low = 1'b0;
            dat_low = 1'b0;
            #250;
            if (k < 11) f[k] = dat_w;
        end
    endtask
endmodule // ppr_dev_model
`default_nettype wire

// ===== sim/tb_top.sv
// bench for one link channel: apb master, wire resolution, peripheral
// assumes short timeout parameters and a 20 MHz system clock
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import ppr_pkg::*;
;
    logic          sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic          clk_low, dat_low;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd;
    ppr_link_out_t link_out;
    int            miscompares = 0, checks = 0, cyc = 0;
    // open-drain wires: low if any party pulls
    wire clk_w = ~(clk_low | link_out.clk_oe);
    wire dat_w = ~(dat_low | link_out.dat_oe);
    ppr_channel #(.BIT_TO_CYC(60), .STA_TO_CYC(400), .FRM_TO_CYC(300)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_clk(clk_w),
        .link_data_in(dat_w), .link_out(link_out));
    ppr_dev_model dev (.clk_w(clk_w), .dat_w(dat_w), .clk_low(clk_low), .dat_low(dat_low));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic results();
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer; an idle edge first keeps drivers single per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // the loop has no cycle limit and only the bench timeout ends a hang; n is then checked to be 2
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(n, 32'h2);
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic rx_case(input logic [5:0] c, input logic [7:0] b,
                           input logic p, input logic s, input logic ok);
        int n;
        n = 0;
        apb(1'b1, PPR_OFF_CTRL, {26'h0, c});
        dev.send(b, p, s);
        do begin
            apb(1'b0, PPR_OFF_STAT, 32'h0);
            n++;
        end while (rd[PPR_ST_RDY] !== 1'b1 && n < 10);
        chk({31'h0, rd[PPR_ST_RDY]}, {31'h0, ok});
        if (ok) begin
            chk({31'h0, link_out.clk_oe}, 32'h1);
            apb(1'b0, PPR_OFF_DATA, 32'h0);
            chk(rd, {24'h0, b});
            apb(1'b0, PPR_OFF_DATA, 32'h0);
            chk(rd, 32'hFF);
            chk({31'h0, link_out.clk_oe}, 32'h0);
        end
    endtask
    task automatic tx_case(input logic [7:0] b);
        logic [10:0] f;
        apb(1'b1, PPR_OFF_CTRL, 32'h3);
        repeat (10) @(posedge sys_clk);
        chk({31'h0, link_out.clk_oe}, 32'h1);
        fork
            dev.recv(f);
            apb(1'b1, PPR_OFF_DATA, {24'h0, b});
        join
        chk({21'h0, f}, {21'h0, 1'b1, ~^b, b, 1'b0});
        repeat (10) @(posedge sys_clk);
        apb(1'b0, PPR_OFF_CTRL, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, PPR_OFF_STAT, 32'h0);
        chk({31'h0, rd[PPR_ST_IDLE]}, 32'h1);
    endtask
    // byte left unread: transmit must wait, then go once it is read
    task automatic hold_case();
        logic [10:0] f;
        dev.send(8'h33, ~^8'h33, 1'b1);
        repeat (10) @(posedge sys_clk);
        apb(1'b1, PPR_OFF_CTRL, 32'h3);
        repeat (10) @(posedge sys_clk);
        apb(1'b1, PPR_OFF_DATA, 32'hC3);
        repeat (20) @(posedge sys_clk);
        chk({28'h0, link_out}, 32'h4);
        fork
            dev.recv(f);
            apb(1'b0, PPR_OFF_DATA, 32'h0);
        join
        chk(rd, 32'h33);
        chk({21'h0, f}, {21'h0, 1'b1, ~^8'hC3, 8'hC3, 1'b0});
    endtask
    // peripheral never clocks: start timeout, hold, then recovery
    task automatic to_case();
        apb(1'b1, PPR_OFF_CTRL, 32'h3);
        repeat (10) @(posedge sys_clk);
        apb(1'b1, PPR_OFF_DATA, 32'h5A);
        repeat (500) @(posedge sys_clk);
        chk({28'h0, link_out}, 32'h4);
        apb(1'b0, PPR_OFF_STAT, 32'h0);
        chk(rd, 32'hB0);
        apb(1'b0, PPR_OFF_CTRL, 32'h0);
        chk(rd, 32'h2);
        apb(1'b0, PPR_OFF_DATA, 32'h0);
        chk(rd, 32'hFF);
        apb(1'b1, PPR_OFF_STAT, 32'hA0);
        apb(1'b0, PPR_OFF_STAT, 32'h0);
        chk(rd, 32'h10);
        chk({28'h0, link_out}, 32'h0);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            chk(32'h0, 32'h1); // hang cut short
            results();
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(1'b0, PPR_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, PPR_OFF_DATA, 32'h0);
        chk(rd, 32'hFF);
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({28'h0, link_out}, 32'h4);
        apb(1'b1, PPR_OFF_CTRL, 32'h2);
        dev.send(8'h00, 1'b1, 1'b1); // primes link-side registers
        repeat (100) @(posedge sys_clk);
        apb(1'b0, PPR_OFF_DATA, 32'h0);
        rx_case(6'h02, 8'h5A, ~^8'h5A, 1'b1, 1'b1);
        rx_case(6'h06, 8'h5A, ^8'h5A, 1'b1, 1'b1);
        rx_case(6'h0A, 8'h3C, ^8'h3C, 1'b1, 1'b1);
        rx_case(6'h02, 8'h3C, ^8'h3C, 1'b1, 1'b0);
        rx_case(6'h12, 8'h81, ~^8'h81, 1'b0, 1'b1);
        rx_case(6'h02, 8'h81, ~^8'h81, 1'b0, 1'b0);
        rx_case(6'h22, 8'h81, ~^8'h81, 1'b0, 1'b1);
        rx_case(6'h12, 8'h81, ~^8'h81, 1'b1, 1'b0);
        rx_case(6'h06, 8'h5A, ~^8'h5A, 1'b1, 1'b0);
        tx_case(8'hA5);
        hold_case();
        to_case();
        apb(1'b1, PPR_OFF_CTRL, 32'h0);
        repeat (5) @(posedge sys_clk);
        chk({28'h0, link_out}, 32'h4);
        results();
    end
endmodule // tb_top
`default_nettype wire
